/* File: rtl/ir_remote_pkg.sv */
// Register map, field layouts and reset values of the remote receiver
package ir_remote_pkg;

    // Word offsets on the register bus
    localparam logic [7:0] OFF_ENABLE = 8'h00;
    localparam logic [7:0] OFF_CTRL1  = 8'h04;
    localparam logic [7:0] OFF_CTRL2  = 8'h08;
    localparam logic [7:0] OFF_CTRL3  = 8'h0c;
    localparam logic [7:0] OFF_CTRL4  = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_BUF1   = 8'h18;
    localparam logic [7:0] OFF_BUF2   = 8'h1c;
    localparam logic [7:0] OFF_BUF3   = 8'h20;
    localparam logic [7:0] OFF_END1   = 8'h24;
    localparam logic [7:0] OFF_END2   = 8'h28;
    localparam logic [7:0] OFF_END3   = 8'h2c;
    localparam logic [7:0] OFF_SRCSEL = 8'h30;

    // Values after reset
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [6:0]  RST_BITS  = 7'h00;
    localparam logic [7:0]  RST_COUNT = 8'h00;

    // Saturation limits of the counters
    localparam logic [7:0] TICK_SAT = 8'hff;
    localparam logic [6:0] BITS_SAT = 7'h7f;

    // Leader thresholds, in sampling clocks
    typedef struct packed {
        logic [7:0] cyc_max;
        logic [7:0] cyc_min;
        logic [7:0] low_max;
        logic [7:0] low_min;
    } leader_cfg_s;

    // Completion limits and event enables
    typedef struct packed {
        logic [4:0] unused_hi;
        logic       leaderless;
        logic       fall_ien;
        logic       leader_ien;
        logic [7:0] unused_lo;
        logic [7:0] low_width;
        logic [7:0] max_cycle;
    } rx_cfg_s;

    // Receive status word
    typedef struct packed {
        logic [19:0] unused;
        logic        low_flag;
        logic        max_flag;
        logic        fall_flag;
        logic        leader_flag;
        logic        leader_seen;
        logic [6:0]  bit_count;
    } rx_stat_s;

endpackage : ir_remote_pkg

/* File: rtl/ir_remote_receiver.sv */
// Pulse-width remote control receiver with an AHB-Lite register slave
`timescale 1ns/1ns

// What this block does
// [RULE1] Source select bit 0 samples on the 32.768kHz clock, 1 on the timer output.
// [RULE2] Software keeps the timer sampling source between 30 and 34 kHz.
// [RULE3] Software disables, re-enables, then sets source select before other registers.
// [RULE4] A valid leader sets the leader-seen flag, then bits decode in sequence.
// [RULE5] With leader event enabled, a leader sets the leader flag and signals.
// [RULE6] Decoded bits go to three receive buffers, at most 72 bits a frame.
// [RULE7] With fall event enabled, each data-bit fall sets its flag and signals.
// [RULE8] After completion the receiver waits for the next leader by itself.
// [RULE9] A newer completed frame overwrites the unread previous result.
// [RULE10] Leaderless mode takes incoming pulses as data without a leader.
// [RULE11] Filter changes level only after the set count of opposite samples.
// [RULE12] Leader checked against min and max period and low width, 8 bits each.
// [RULE13] Software orders the leader thresholds; cycle max zero means no leader.
// [RULE14] A frame without a leader never raises the leader event.
// [RULE15] A fall period at or above the threshold is 1, below it is 0.
// [RULE16] Reception ends on whichever enabled completion condition comes first.
// [RULE17] No fall within the max bit cycle completes reception, sets max flag.
// [RULE18] With expected counts set, max cycle completes only on a matching count.
// [RULE19] Software sets at least one completion condition before enabling.
// [RULE20] Low longer than the excess low width completes, sets low flag.
// [RULE21] Clearing receive enable stops at once and discards partial data.
// [RULE22] The raw input passes two sampling-clock flip-flops before the filter.
module ir_remote_receiver #(
    parameter int MAX_BITS = 72
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic        lf_clk,
    input  wire logic        timer_sample_source,
    input  wire logic        remote_in,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             rx_event
);

    if (MAX_BITS < 1 || MAX_BITS > 96) begin : g_bits_chk
        $error("MAX_BITS must lie in 1..96");
    end

    typedef enum logic [1:0] {ST_OFF, ST_WAIT, ST_LEAD, ST_DATA} state_e;

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic                      enable_q;
    logic                      srcsel_q;
    ir_remote_pkg::leader_cfg_s lcfg_q;
    ir_remote_pkg::rx_cfg_s    rcfg_q;
    logic [6:0]                thr_q;
    logic [3:0]                nc_q;
    logic [6:0]                end_q [3];
    ir_remote_pkg::rx_stat_s   stat_q;
    logic [95:0]               rbuf_q;
    logic [95:0]               sh_q;
    logic                      wr_q;
    logic [7:0]                wa_q;
    logic [31:0]               rdata_q;
    logic                      ev_q;
    logic                      src_q;
    logic                      s1_q;
    logic                      s2_q;
    logic                      filt_q;
    logic                      filt_p_q;
    logic [3:0]                nf_q;
    logic [7:0]                tcnt_q;
    logic [7:0]                low_q;
    logic [6:0]                bits_q;
    state_e                    state_q;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    // Word read selection, unmapped offsets read as zero
    function automatic logic [31:0] rd_word(input logic [7:0] a);
        case (a)
            ir_remote_pkg::OFF_ENABLE: rd_word = {31'h0, enable_q};
            ir_remote_pkg::OFF_CTRL1:  rd_word = lcfg_q;
            ir_remote_pkg::OFF_CTRL2:  rd_word = rcfg_q;
            ir_remote_pkg::OFF_CTRL3:  rd_word = {25'h0, thr_q};
            ir_remote_pkg::OFF_CTRL4:  rd_word = {28'h0, nc_q};
            ir_remote_pkg::OFF_STATUS: rd_word = stat_q;
            ir_remote_pkg::OFF_BUF1:   rd_word = rbuf_q[31:0];
            ir_remote_pkg::OFF_BUF2:   rd_word = rbuf_q[63:32];
            ir_remote_pkg::OFF_BUF3:   rd_word = rbuf_q[95:64];
            ir_remote_pkg::OFF_END1:   rd_word = {25'h0, end_q[0]};
            ir_remote_pkg::OFF_END2:   rd_word = {25'h0, end_q[1]};
            ir_remote_pkg::OFF_END3:   rd_word = {25'h0, end_q[2]};
            ir_remote_pkg::OFF_SRCSEL: rd_word = {31'h0, srcsel_q};
            default:                   rd_word = ir_remote_pkg::RST_WORD;
        endcase
    endfunction : rd_word

    // Expected count hit: zero means that count is not in use
    function automatic logic end_hit(input logic [6:0] e,
                                     input logic [6:0] n);
        end_hit = (e != 7'h00) && (e == n);
    endfunction : end_hit

    wire acc     = hsel & htrans[1] & hready;
    wire word_ok = (hsize == 3'h2);

    // Address phase captured; read data ready for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q    <= 1'b0;
            wa_q    <= 8'h00;
            rdata_q <= ir_remote_pkg::RST_WORD;
        end else begin
            wr_q    <= acc & hwrite & word_ok;
            wa_q    <= haddr[7:0];
            rdata_q <= (acc & ~hwrite) ? rd_word(haddr[7:0])
                                       : ir_remote_pkg::RST_WORD;
        end
    end

    // Register writes in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_q <= 1'b0;
            srcsel_q <= 1'b0;
            lcfg_q   <= ir_remote_pkg::RST_WORD;
            rcfg_q   <= ir_remote_pkg::RST_WORD;
            thr_q    <= ir_remote_pkg::RST_BITS;
            nc_q     <= 4'h0;
            end_q    <= '{default: ir_remote_pkg::RST_BITS};
        end else if (wr_q) begin
            case (wa_q)
                ir_remote_pkg::OFF_ENABLE: enable_q <= hwdata[0];
                ir_remote_pkg::OFF_CTRL1:  lcfg_q   <= hwdata;
                ir_remote_pkg::OFF_CTRL2:  rcfg_q   <= hwdata;
                ir_remote_pkg::OFF_CTRL3:  thr_q    <= hwdata[6:0];
                ir_remote_pkg::OFF_CTRL4:  nc_q     <= hwdata[3:0];
                ir_remote_pkg::OFF_END1:   end_q[0] <= hwdata[6:0];
                ir_remote_pkg::OFF_END2:   end_q[1] <= hwdata[6:0];
                ir_remote_pkg::OFF_END3:   end_q[2] <= hwdata[6:0];
                ir_remote_pkg::OFF_SRCSEL: srcsel_q <= hwdata[0];
                default:                   ;
            endcase
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;
    assign rx_event  = ev_q;

    ////////////////////////////////////////////////////////////////////////
    // Sampling and noise filter

    // [RULE1] source choice
    wire src  = srcsel_q ? timer_sample_source : lf_clk;
    wire tick = src & ~src_q;
    wire [3:0] nc_eff = (nc_q == 4'h0) ? 4'h1 : nc_q;
    wire flip = (s2_q != filt_q);
    wire nf_done = ({1'b0, nf_q} + 5'h01) >= {1'b0, nc_eff};

    // [RULE22] two-stage chain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_q <= 1'b0;
            s1_q  <= 1'b1;
            s2_q  <= 1'b1;
        end else begin
            src_q <= src;
            if (tick) begin
                s1_q <= remote_in;
                s2_q <= s1_q;
            end
        end
    end

    // [RULE11] consecutive opposite samples
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            filt_q   <= 1'b1;
            filt_p_q <= 1'b1;
            nf_q     <= 4'h0;
        end else begin
            filt_p_q <= filt_q;
            if (tick) begin
                filt_q <= (flip && nf_done) ? s2_q : filt_q;
                nf_q   <= (flip && !nf_done) ? nf_q + 4'h1 : 4'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoder

    wire fall = filt_p_q & ~filt_q;
    wire rise = ~filt_p_q & filt_q;
    wire no_leader = rcfg_q.leaderless || (lcfg_q.cyc_max == 8'h00);
    // [RULE12] period and low width windows
    wire low_ok = (lcfg_q.low_max == 8'h00) ||
                  (low_q >= lcfg_q.low_min && low_q <= lcfg_q.low_max);
    wire lead_ok = low_ok && tcnt_q >= lcfg_q.cyc_min &&
                   tcnt_q <= lcfg_q.cyc_max;
    wire lead_late = tcnt_q > lcfg_q.cyc_max;
    wire bit_val = {1'b0, tcnt_q} >= {2'b00, thr_q};
    wire lw_hit = ~filt_q && rcfg_q.low_width != 8'h00 &&
                  tcnt_q > rcfg_q.low_width;
    wire mc_hit = rcfg_q.max_cycle != 8'h00 &&
                  tcnt_q >= rcfg_q.max_cycle;
    wire ends_off = end_q[0] == 7'h00 && end_q[1] == 7'h00 &&
                    end_q[2] == 7'h00;
    wire cnt_ok = ends_off || end_hit(end_q[0], bits_q) ||
                  end_hit(end_q[1], bits_q) || end_hit(end_q[2], bits_q);
    // [RULE16] first condition seen ends the frame
    wire done = ~fall && (lw_hit || (mc_hit && cnt_ok));
    wire drop = ~fall && ~lw_hit && mc_hit && !cnt_ok;
    wire [7:0] tcnt_inc = (tcnt_q == ir_remote_pkg::TICK_SAT) ? tcnt_q
                                                             : tcnt_q + 8'h01;

    // Sample-clock counter since the last fall
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tcnt_q <= ir_remote_pkg::RST_COUNT;
            low_q  <= ir_remote_pkg::RST_COUNT;
        end else begin
            tcnt_q <= fall ? ir_remote_pkg::RST_COUNT
                           : (tick ? tcnt_inc : tcnt_q);
            low_q  <= rise ? tcnt_q : low_q;
        end
    end

    // Frame state, bit store and status
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_OFF;
            sh_q    <= 96'h0;
            rbuf_q  <= 96'h0;
            bits_q  <= ir_remote_pkg::RST_BITS;
            stat_q  <= ir_remote_pkg::RST_WORD;
            ev_q    <= 1'b0;
        end else begin
            ev_q <= 1'b0;
            // [RULE21] disable discards the frame
            if (!enable_q) begin
                state_q <= ST_OFF;
                sh_q    <= 96'h0;
                bits_q  <= ir_remote_pkg::RST_BITS;
            end else begin
                case (state_q)
                    ST_OFF: state_q <= ST_WAIT;
                    ST_WAIT: if (fall) begin
                        sh_q   <= 96'h0;
                        bits_q <= ir_remote_pkg::RST_BITS;
                        // [RULE10] no leader needed
                        state_q <= no_leader ? ST_DATA : ST_LEAD;
                        // [RULE14] leaderless start never flags a leader
                        if (no_leader) begin
                            stat_q.leader_seen <= 1'b0;
                            stat_q.leader_flag <= 1'b0;
                        end
                    end
                    ST_LEAD: if (fall && lead_ok) begin
                        // [RULE4] leader seen, data follows
                        state_q            <= ST_DATA;
                        stat_q.leader_seen <= 1'b1;
                        // [RULE5] leader event
                        stat_q.leader_flag <= rcfg_q.leader_ien;
                        ev_q               <= rcfg_q.leader_ien;
                    end else if (!fall && lead_late) begin
                        state_q <= ST_WAIT;
                    end
                    ST_DATA: if (fall) begin
                        // [RULE15] threshold decision
                        // [RULE6] store up to the limit
                        if ({25'h0, bits_q} < MAX_BITS) begin
                            sh_q[bits_q] <= bit_val;
                        end
                        if (bits_q != ir_remote_pkg::BITS_SAT) begin
                            bits_q <= bits_q + 7'h01;
                        end
                        // [RULE7] fall event
                        if (rcfg_q.fall_ien) begin
                            stat_q.fall_flag <= 1'b1;
                            ev_q             <= 1'b1;
                        end
                    end else if (done) begin
                        // [RULE9] result overwritten on each completion
                        rbuf_q           <= sh_q;
                        stat_q.bit_count <= bits_q;
                        // [RULE17] max cycle flag
                        stat_q.max_flag  <= mc_hit && cnt_ok;
                        // [RULE20] low width flag
                        stat_q.low_flag  <= lw_hit;
                        ev_q             <= 1'b1;
                        // [RULE8] back to waiting
                        state_q          <= ST_WAIT;
                    end else if (drop) begin
                        // [RULE18] count mismatch, wait for a leader
                        state_q <= ST_WAIT;
                    end
                    default: state_q <= ST_OFF;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sync_chain_a: assert property (tick |=> s2_q == $past(s1_q)) // [RULE22]
        else $error("sync chain did not advance");

    filter_hold_a: assert property ( // [RULE11]
        tick && flip && !nf_done |=> filt_q == $past(filt_q))
        else $error("filter changed too early");

    leader_gate_a: assert property ( // [RULE5]
        $rose(stat_q.leader_flag) |-> rcfg_q.leader_ien && stat_q.leader_seen
            && ev_q) else $error("leader flag without enable");

    no_lead_irq_a: assert property ( // [RULE14]
        state_q == ST_WAIT && enable_q && fall && no_leader
            |=> !stat_q.leader_flag ##1 state_q == ST_DATA)
        else $error("leader event on leaderless frame");

    fall_flag_a: assert property ( // [RULE7]
        state_q == ST_DATA && enable_q && fall && rcfg_q.fall_ien
            |=> stat_q.fall_flag && ev_q) else $error("fall event missing");

    bit_decode_a: assert property ( // [RULE15]
        state_q == ST_DATA && enable_q && fall && bits_q < 7'd72
            |=> sh_q[$past(bits_q)] == $past(bit_val)
                && bits_q == $past(bits_q) + 7'h01)
        else $error("data bit stored wrongly");

    max_done_a: assert property ( // [RULE17]
        state_q == ST_DATA && enable_q && done && !lw_hit
            |=> stat_q.max_flag && ev_q && state_q == ST_WAIT
                && rbuf_q == $past(sh_q)) else $error("max cycle end wrong");

    low_done_a: assert property ( // [RULE20]
        state_q == ST_DATA && enable_q && !fall && lw_hit
            |=> stat_q.low_flag && ev_q
                && stat_q.bit_count == $past(bits_q))
        else $error("low width end wrong");

    count_drop_a: assert property ( // [RULE18]
        state_q == ST_DATA && enable_q && drop
            |=> state_q == ST_WAIT && !ev_q
                && $stable(rbuf_q)) else $error("mismatch completed");

    disable_a: assert property ( // [RULE21]
        !enable_q |=> state_q == ST_OFF && bits_q == 7'h00
            ##1 sh_q == 96'h0) else $error("disable did not discard");

    leader_cv: cover property (state_q == ST_LEAD ##1 state_q == ST_DATA);
    done_cv: cover property (state_q == ST_DATA && done);
    drop_cv: cover property (state_q == ST_DATA && drop);

endmodule : ir_remote_receiver

/* File: verification/remote_source.sv */
// Remote control transmitter model with free-running sampling sources
`timescale 1ns/1ns
module remote_source (
    input  wire logic hclk,
    input  wire logic use_timer,
    output logic      lf_clk,
    output logic      timer_sample_source,
    output logic      remote_in
);
    logic [3:0] lf_cnt_q = 4'h0;
    logic [3:0] tm_cnt_q = 4'h0;

    initial remote_in = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Both sources run free; rates are scaled up to keep frames short
    // fixed-rate low-frequency clock and timer source
    always_ff @(posedge hclk) begin
        lf_cnt_q <= (lf_cnt_q == 4'h7) ? 4'h0 : lf_cnt_q + 4'h1;
        tm_cnt_q <= (tm_cnt_q == 4'hb) ? 4'h0 : tm_cnt_q + 4'h1;
    end
    assign lf_clk              = lf_cnt_q[2];
    assign timer_sample_source = (tm_cnt_q >= 4'h6);

    ////////////////////////////////////////////////////////////////////////
    // Waits n ticks of the source that the receiver should be using
    task automatic ticks(input int n);
        repeat (n) begin
            if (use_timer) @(posedge timer_sample_source);
            else @(posedge lf_clk);
        end
        @(posedge hclk);
    endtask : ticks

    // Drives a level and holds it for n ticks; the line idles high
    task automatic hold(input logic v, input int n);
        remote_in <= v;
        ticks(n);
    endtask : hold

    // One fall-to-fall period, with an optional short low glitch; the
    // glitch follows three high ticks so the filtered rise is already seen
    task automatic seg(input int low, input int per, input int g);
        hold(1'b0, low);
        if (g > 0) begin
            hold(1'b1, 3);
            hold(1'b0, g);
            hold(1'b1, per - low - 3 - g);
        end else begin
            hold(1'b1, per - low);
        end
    endtask : seg

    // Leader, n bits (0 is 7 ticks, 1 is 10 ticks), closing fall, idle;
    // every high part except the one after a glitch lasts at least three ticks to pass the filter
    task automatic frame(input bit ldr, input int n, input logic [71:0] d,
                         input int gl_at, input int stop_low);
        if (ldr) begin
            seg(12, 24, 0);
        end
        for (int k = 0; k < n; k++) begin
            seg(4, d[k] ? 10 : 7, (k == gl_at) ? 2 : 0);
        end
        hold(1'b0, stop_low);
        hold(1'b1, 40);
    endtask : frame
endmodule : remote_source

/* File: verification/tb_top.sv */
// Self-checking bench of the remote receiver: bus tasks and frame tests
`timescale 1ns/1ns
module tb_top;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        use_timer;
    logic [31:0] rd;
    wire         hreadyout;
    wire         hresp;
    wire  [31:0] hrdata;
    wire         rx_event;
    wire         lf_clk;
    wire         timer_src;
    wire         remote_in;
    int          miscompares = 0;
    int          total_checks = 0;
    int          ev_cnt = 0;
    int          cycles = 0;
    logic [7:0]  ta [6] = '{8'h30, 8'h04, 8'h0c, 8'h10, 8'h24, 8'h34};
    logic [31:0] tw [6] = '{32'hffff_ffff, 32'h1c14_0e0a, 32'hffff_ffff,
                            32'hffff_fff3, 32'hffff_ff85, 32'hffff_ffff};
    logic [31:0] te [6] = '{32'h1, 32'h1c14_0e0a, 32'h7f, 32'h3, 32'h5,
                            32'h0};

    ir_remote_receiver DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .lf_clk(lf_clk),
        .timer_sample_source(timer_src), .remote_in(remote_in),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rx_event(rx_event)
    );

    remote_source src (
        .hclk(hclk), .use_timer(use_timer), .lf_clk(lf_clk),
        .timer_sample_source(timer_src), .remote_in(remote_in)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock, event counter and hang guard
    initial hclk = 1'b0;
    always #50 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles++;
        if (rx_event === 1'b1) ev_cnt++;
        if (cycles == 60000) begin
            miscompares++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and bus tasks
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // One single word transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, rd);
    endtask : wr

    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
        xfer(1'b0, a, 32'h0, rd);
        chk(nm, rd, e);
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask : rchk

    // Sends a frame and checks how many events it raised
    task automatic run(input bit ldr, input int n, input logic [71:0] d,
                       input int stop, input int nev);
        ev_cnt = 0;
        src.frame(ldr, n, d, -1, stop);
        for (int i = 0; i < 3000 && ev_cnt < nev; i++) @(posedge hclk);
        chk("events", ev_cnt, nev);
    endtask : run

    // Control word: no leader, fall and leader enables; limits 8 and 14
    function automatic logic [31:0] c2(input logic ll, fi, li);
        return {5'h0, ll, fi, li, 8'h00, 8'h08, 8'h0e};
    endfunction : c2

    // Status word from count and {low, max, fall, leader, seen}
    function automatic logic [31:0] stw(input logic [6:0] n,
                                        input logic [4:0] f);
        return {20'h0, f, n};
    endfunction : stw

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        use_timer = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 14; i++)
            rchk("reset", 8'(4 * i), 32'h0);
        for (int i = 0; i < 6; i++) begin
            wr(ta[i], tw[i]);
            rchk("readback", ta[i], te[i]);
        end
        wr(ir_remote_pkg::OFF_SRCSEL, 32'h0);
        wr(ir_remote_pkg::OFF_CTRL3, 32'h8);
        wr(ir_remote_pkg::OFF_END1, 32'h0);
        wr(ir_remote_pkg::OFF_CTRL2, c2(1'b0, 1'b0, 1'b1));
        wr(ir_remote_pkg::OFF_ENABLE, 32'h1);
        $display("test registers done");
        ev_cnt = 0;
        src.frame(1'b1, 8, 72'ha5, 0, 4);
        for (int i = 0; i < 3000 && ev_cnt < 2; i++) @(posedge hclk);
        chk("events", ev_cnt, 2);
        rchk("status", 8'h14, stw(7'd8, 5'b01011));
        rchk("buf1", 8'h18, 32'ha5);
        $display("test leader frame done");
        wr(ir_remote_pkg::OFF_CTRL2, c2(1'b0, 1'b1, 1'b0));
        ev_cnt = 0;
        src.frame(1'b1, 4, 72'h3, -1, 4);
        chk("fall events", ev_cnt, 5);
        rchk("status", 8'h14, stw(7'd4, 5'b01101));
        rchk("buf1", 8'h18, 32'h3);
        $display("test fall events done");
        wr(ir_remote_pkg::OFF_END1, 32'h5);
        wr(ir_remote_pkg::OFF_END2, 32'h48);
        wr(ir_remote_pkg::OFF_CTRL2, c2(1'b0, 1'b0, 1'b1));
        run(1'b1, 72, 72'h5a_9abc_def0_1234_5678, 4, 2);
        rchk("status", 8'h14, stw(7'h48, 5'b01111));
        rchk("buf1", 8'h18, 32'h1234_5678);
        rchk("buf2", 8'h1c, 32'h9abc_def0);
        rchk("buf3", 8'h20, 32'h5a);
        run(1'b1, 3, 72'h5, 4, 1);
        rchk("status", 8'h14, stw(7'h48, 5'b01111));
        $display("test bit counts done");
        wr(ir_remote_pkg::OFF_END1, 32'h0);
        wr(ir_remote_pkg::OFF_END2, 32'h0);
        run(1'b1, 3, 72'h5, 20, 2);
        rchk("status", 8'h14, stw(7'd3, 5'b10111));
        rchk("buf1", 8'h18, 32'h5);
        $display("test low width done");
        wr(ir_remote_pkg::OFF_CTRL2, c2(1'b1, 1'b0, 1'b1));
        run(1'b0, 4, 72'h9, 4, 1);
        rchk("status", 8'h14, stw(7'd4, 5'b01100));
        rchk("buf1", 8'h18, 32'h9);
        $display("test leaderless done");
        // disable, enable, source select before other registers
        wr(ir_remote_pkg::OFF_ENABLE, 32'h0);
        wr(ir_remote_pkg::OFF_ENABLE, 32'h1);
        wr(ir_remote_pkg::OFF_SRCSEL, 32'h1);
        wr(ir_remote_pkg::OFF_CTRL2, c2(1'b0, 1'b0, 1'b1));
        use_timer <= 1'b1;
        run(1'b1, 8, 72'h3c, 4, 2);
        rchk("status", 8'h14, stw(7'd8, 5'b01111));
        rchk("buf1", 8'h18, 32'h3c);
        $display("test timer source done");
        fork
            src.frame(1'b1, 16, 72'hffff, -1, 4);
            begin
                repeat (700) @(posedge hclk);
                wr(ir_remote_pkg::OFF_ENABLE, 32'h0);
            end
        join
        rchk("status", 8'h14, stw(7'd8, 5'b01111));
        rchk("buf1", 8'h18, 32'h3c);
        $display("test abort done");
        end_of_test();
    end
endmodule : tb_top
